//--- logic/boh_consts.svh
// timing and encoding constants for the bus ownership handshake
// assumes inclusion by the package and the design modules
`ifndef BOH_CONSTS_SVH
`define BOH_CONSTS_SVH
`define BOH_WIDTH_32      2'h0
`define BOH_WIDTH_16      2'h1
`define BOH_WIDTH_8       2'h2
`define BOH_BEATS_32      3'h1
`define BOH_BEATS_16      3'h2
`define BOH_BEATS_8       3'h4
`define BOH_CLK_PERIOD_NS 100
`endif

//--- logic/boh_pkg.sv
// types for the bus ownership handshake
// assumes boh_consts.svh is on the include path
`include "boh_consts.svh"
package boh_pkg;
  // kind of transfer the core is running
  typedef enum logic [1:0] {
    BOH_OP_SINGLE = 2'h0,
    BOH_OP_DOUBLE = 2'h1,
    BOH_OP_ATOMIC = 2'h2
  } boh_op_t;
  // request from the core bus unit
  typedef struct packed {
    logic    start;   // pulse: new bus operation or its second word begins
    boh_op_t op;
    logic    write;
    logic [1:0] width; // bus width code of the target area
  } boh_core_req_t;
endpackage : boh_pkg

//--- logic/boh_beat_counter.sv
// narrow-cycle beat counter: counts ready pulses of one data word
// assumes ready pulses of one cycle each, synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
`include "boh_consts.svh"
module boh_beat_counter (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       load,
  input  wire logic [1:0] width,
  input  wire logic       beat,
  output logic            word_done
);
  logic [2:0] left;
  logic [2:0] next_left;
  logic [2:0] beats;

  always_comb begin
    unique case (width)
      `BOH_WIDTH_16: beats = `BOH_BEATS_16;
      `BOH_WIDTH_8:  beats = `BOH_BEATS_8;
      default:       beats = `BOH_BEATS_32;
    endcase
  end

  always_comb begin
    next_left = left;
    if (load) begin
      next_left = beats;
    end else if (beat && left != 3'h0) begin
      next_left = left - 3'h1;
    end
  end

  // the word ends on its last narrow ready pulse
  assign word_done = beat && (left == 3'h1);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      left <= 3'h0;
    end else if (clk_en) begin
      left <= next_left;
    end
  end
endmodule : boh_beat_counter
`default_nettype wire

//--- logic/boh_bus_ownership.sv
// bus ownership handshake with ready mirror
// assumes one bus clock; external inputs synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
`include "boh_consts.svh"
module boh_bus_ownership (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  input  wire boh_pkg::boh_core_req_t core_req,
  input  wire logic                   core_need_bus,
  input  wire logic                   int_ready,
  input  wire logic                   ext_ready,
  input  wire logic                   ext_master_bus_request,
  input  wire logic                   core_read_write_direction,
  input  wire logic                   read_write_direction_in,
  output logic                        read_write_direction_out,
  output logic                        read_write_direction_oe,
  output logic                        ready_mirror_out,
  output logic                        bus_grant_out,
  output logic                        cpu_bus_reclaim_request,
  output logic                        bus_lock_out,
  output logic                        core_busy,
  output logic                        ext_write_seen
);
  import boh_pkg::*;

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_FIRST  = 4'b0010,
    ST_SECOND = 4'b0100,
    ST_GRANT  = 4'b1000
  } boh_state_t;

  boh_state_t state;
  boh_state_t next_state;
  boh_op_t    op;
  boh_op_t    next_op;
  logic [1:0] width;
  logic [1:0] next_width;
  logic       early_rel;
  logic       next_early_rel;
  logic       int_rdy_q;
  logic       next_int_rdy_q;
  logic       lock;
  logic       next_lock;
  logic       ext_wr;
  logic       next_ext_wr;
  logic       beat;
  logic       word_done;
  logic       load;
  logic       granted;
  logic [1:0] cnt_width;
  logic       cnt_beat;

  // ------------------------------------------------------------
  // ready mirror
  // ------------------------------------------------------------
  // external ready overrides the wait count and passes straight through
  assign beat             = ext_ready || int_ready;
  assign ready_mirror_out = int_rdy_q || ext_ready;

  always_comb begin
    // internal ready is re-timed so the mirror never shows the wait-state decode
    next_int_rdy_q = int_ready;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_rdy_q <= 1'b0;
    end else if (clk_en) begin
      int_rdy_q <= next_int_rdy_q;
    end
  end

  // ------------------------------------------------------------
  // narrow-cycle counting
  // ------------------------------------------------------------
  // the core pulses start once per word: in idle for the first word and in the
  // second-word state for the store of an atomic or the second half of a double
  assign load      = core_req.start && (state == ST_IDLE || state == ST_SECOND);
  // a new operation takes its width from the request, a second word from the latch
  assign cnt_width = (state == ST_IDLE) ? core_req.width : width;
  // beats of a granted-away bus belong to the external master and are not counted
  assign cnt_beat  = beat && (state == ST_FIRST || state == ST_SECOND);

  boh_beat_counter u_beats (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .load      (load),
    .width     (cnt_width),
    .beat      (cnt_beat),
    .word_done (word_done)
  );

  // ------------------------------------------------------------
  // ownership sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_op        = op;
    next_width     = width;
    next_early_rel = early_rel;
    next_lock      = lock;
    unique case (state)
      ST_IDLE: begin
        next_early_rel = 1'b0;
        if (core_req.start) begin
          next_state = ST_FIRST;
          next_op    = core_req.op;
          next_width = core_req.width;
          next_lock  = (core_req.op == BOH_OP_ATOMIC);
        end else if (ext_master_bus_request) begin
          // start wins over a request that arrives in the same cycle
          next_state = ST_GRANT;
        end
      end
      ST_FIRST: begin
        if (op == BOH_OP_DOUBLE && ext_master_bus_request) begin
          next_early_rel = 1'b1;
        end
        if (word_done) begin
          if (op == BOH_OP_SINGLE) begin
            // whole object sent before any release
            next_state = ext_master_bus_request ? ST_GRANT : ST_IDLE;
          end else if (op == BOH_OP_DOUBLE &&
                       (early_rel || ext_master_bus_request)) begin
            next_state = ST_GRANT;
          end else begin
            // atomic store or second word follows without release
            next_state = ST_SECOND;
          end
        end
      end
      ST_SECOND: begin
        // a resumed double must not be resumed again after a later grant
        next_early_rel = 1'b0;
        if (word_done) begin
          next_lock  = 1'b0;
          next_state = ext_master_bus_request ? ST_GRANT : ST_IDLE;
        end
      end
      ST_GRANT: begin
        // start pulses are refused here; the core repeats them once the bus is back
        next_lock = 1'b0;
        if (!ext_master_bus_request) begin
          // resume an unfinished double word
          next_state = early_rel ? ST_SECOND : ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // second word of a resumed double restarts the beat count
  // via core_req.start from the core bus unit

  // ------------------------------------------------------------
  // grant, reclaim, lock and direction pin
  // ------------------------------------------------------------
  assign granted                  = (state == ST_GRANT);
  assign bus_grant_out            = granted;
  assign cpu_bus_reclaim_request  = granted && core_need_bus;
  assign bus_lock_out             = lock;
  assign core_busy                = (state != ST_IDLE);
  assign read_write_direction_oe  = !granted;
  assign read_write_direction_out = granted ? 1'b1 : core_read_write_direction;
  assign ext_write_seen           = ext_wr;

  always_comb begin
    // low on the pin from the external master means write
    next_ext_wr = granted && !read_write_direction_in;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_wr <= 1'b0;
    end else if (clk_en) begin
      ext_wr <= next_ext_wr;
    end
  end

  // ------------------------------------------------------------
  // sequencer registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      op        <= BOH_OP_SINGLE;
      width     <= `BOH_WIDTH_32;
      early_rel <= 1'b0;
      lock      <= 1'b0;
    end else if (clk_en) begin
      state     <= next_state;
      op        <= next_op;
      width     <= next_width;
      early_rel <= next_early_rel;
      lock      <= next_lock;
    end
  end
endmodule : boh_bus_ownership
`default_nettype wire

//--- test/boh_ext_master.sv
// far-side bus master model: requests the bus and drives the direction pin while granted
// assumes the bench supplies want and write and resolves the shared pin with a pull-up
`timescale 1ns/1ps
`default_nettype none
module boh_ext_master (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic want,
  input  wire logic write,
  input  wire logic bus_grant_out,
  input  wire logic cpu_bus_reclaim_request,
  output logic      ext_master_bus_request,
  output logic      drive_oe,
  output logic      drive_val
);
  // request held until want drops; released on the next clock edge when the core asks for the bus back
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_master_bus_request <= 1'b0;
    end else begin
      ext_master_bus_request <= want && !cpu_bus_reclaim_request;
    end
  end
  // drives the direction pin only while granted and still requesting
  assign drive_oe  = bus_grant_out && ext_master_bus_request;
  // low on the direction pin means write
  assign drive_val = !write;
endmodule : boh_ext_master
`default_nettype wire

//--- test/boh_monitor.sv
// assertion checker for the bus ownership handshake
// assumes binding into boh_bus_ownership, one clock domain
`timescale 1ns/1ps
`default_nettype none
module boh_monitor
  import boh_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  input wire logic                   clk_en,
  input wire logic                   int_ready,
  input wire logic                   ext_ready,
  input wire logic                   core_busy,
  input wire logic                   ext_master_bus_request,
  input wire logic                   core_need_bus,
  input wire boh_pkg::boh_core_req_t core_req,
  input wire logic                   ready_mirror_out,
  input wire logic                   bus_grant_out,
  input wire logic                   cpu_bus_reclaim_request,
  input wire logic                   bus_lock_out,
  input wire logic                   read_write_direction_oe,
  input wire logic                   read_write_direction_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence atomic_go;
    core_req.start && core_req.op == BOH_OP_ATOMIC && !core_busy && !bus_grant_out && clk_en;
  endsequence
  a_mirror_ext: assert property (ext_ready |-> ready_mirror_out)
    else $error("ext ready not mirrored");
  a_mirror_int: assert property (int_ready && clk_en |=> ready_mirror_out)
    else $error("int ready not mirrored next cycle");
  a_mirror_src: assert property ($past(clk_en) && ready_mirror_out |-> ext_ready || $past(int_ready))
    else $error("mirror high without ready");
  a_reclaim_eq: assert property (cpu_bus_reclaim_request == (bus_grant_out && core_need_bus))
    else $error("reclaim request wrong");
  a_grant_hold: assert property (bus_grant_out && ext_master_bus_request |=> bus_grant_out)
    else $error("grant lost while requested");
  a_grant_drop: assert property (bus_grant_out && !ext_master_bus_request && clk_en |=> !bus_grant_out)
    else $error("grant kept after request drop");
  a_grant_cause: assert property ($rose(bus_grant_out) |-> $past(ext_master_bus_request))
    else $error("grant without request");
  a_grant_boundary: assert property ($rose(bus_grant_out) |->
      !$past(core_busy) || $past(int_ready) || $past(ext_ready))
    else $error("grant inside a word");
  a_dir_input: assert property (bus_grant_out |-> !read_write_direction_oe && read_write_direction_out)
    else $error("direction pin driven in grant");
  a_lock_start: assert property (atomic_go |=> bus_lock_out)
    else $error("lock missing on atomic");
  a_lock_kept: assert property (bus_lock_out |-> !bus_grant_out)
    else $error("bus granted during lock");
endmodule : boh_monitor
bind boh_bus_ownership boh_monitor u_mon (.core_clk, .sys_rst, .clk_en, .int_ready, .ext_ready,
  .core_busy, .ext_master_bus_request, .core_need_bus, .core_req, .ready_mirror_out,
  .bus_grant_out, .cpu_bus_reclaim_request, .bus_lock_out, .read_write_direction_oe,
  .read_write_direction_out);
`default_nettype wire

//--- test/tb_bus_ownership_handshake.sv
// self-checking bench for the bus ownership handshake
// assumes boh_ext_master at the far side and a pulled-up direction pin
`timescale 1ns/1ps
`default_nettype none
`include "boh_consts.svh"
module tb_bus_ownership_handshake;
  import boh_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, core_need_bus = 1'b0, int_ready = 1'b0;
  logic ext_ready = 1'b0, core_read_write_direction = 1'b1, want = 1'b0, rel;
  logic clk_en = 1'b1, mst_write = 1'b0;
  boh_core_req_t core_req = '0;
  logic ext_master_bus_request, rd_oe, rd_out, m_oe, m_val, ready_mirror_out, bus_grant_out;
  logic cpu_bus_reclaim_request, bus_lock_out, core_busy, ext_write_seen;
  wire read_write_direction_pin = rd_oe ? rd_out : (m_oe ? m_val : 1'b1);
  int n_fail = 0, cmp_count = 0;
  always #50 core_clk = ~core_clk;
  boh_bus_ownership u_dut (.core_clk, .sys_rst, .clk_en, .core_req, .core_need_bus,
    .int_ready, .ext_ready, .ext_master_bus_request, .core_read_write_direction,
    .read_write_direction_in(read_write_direction_pin), .read_write_direction_out(rd_out),
    .read_write_direction_oe(rd_oe), .ready_mirror_out, .bus_grant_out,
    .cpu_bus_reclaim_request, .bus_lock_out, .core_busy, .ext_write_seen);
  boh_ext_master u_mst (.core_clk, .sys_rst, .want, .bus_grant_out, .cpu_bus_reclaim_request,
    .write(mst_write), .ext_master_bus_request, .drive_oe(m_oe), .drive_val(m_val));
  task automatic chk(input string nm, input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic beat(input bit use_ext);
    if (use_ext) ext_ready = 1'b1;
    else int_ready = 1'b1;
    #1 chk("mirror_now", ready_mirror_out, use_ext);
    @(negedge core_clk);
    ext_ready = 1'b0;
    int_ready = 1'b0;
    #1 if (!use_ext) chk("mirror_int", ready_mirror_out, 1'b1);
  endtask : beat
  task automatic release_bus;
    chk("oe", rd_oe, 1'b0);
    @(negedge core_clk);
    chk("wr_seen", ext_write_seen, mst_write);
    core_need_bus = 1'b1;
    #1 chk("reclaim", cpu_bus_reclaim_request, 1'b1);
    repeat (2) @(negedge core_clk);
    chk("grant_drop", bus_grant_out, 1'b0);
    chk("reclaim_off", cpu_bus_reclaim_request, 1'b0);
    want = 1'b0;
    core_need_bus = 1'b0;
  endtask : release_bus
  // rq: word during which the master starts asking
  task automatic run_op(input boh_op_t op, input logic [1:0] wd, input int nb, input int rq,
                        input logic wr);
    for (int w = 0; w < ((op == BOH_OP_SINGLE) ? 1 : 2); w++) begin
      core_req = '{1'b1, op, wr, wd};
      core_read_write_direction = !wr;
      mst_write = wr;
      if (w == rq) want = 1'b1;
      @(negedge core_clk);
      core_req.start = 1'b0;
      chk("busy", core_busy, 1'b1);
      for (int b = 0; b < nb; b++) begin
        chk("read_write_direction_out", rd_out, !wr);
        beat(b[0]);
        rel = want && b == nb - 1 && !(op == BOH_OP_ATOMIC && w == 0);
        chk("grant", bus_grant_out, rel);
        chk("lock", bus_lock_out, op == BOH_OP_ATOMIC && (w == 0 || b < nb - 1));
      end
      if (rel) release_bus();
    end
    @(negedge core_clk);
  endtask : run_op
  task automatic t_single;
    run_op(BOH_OP_SINGLE, `BOH_WIDTH_32, `BOH_BEATS_32, 0, 1'b0);
  endtask : t_single
  task automatic t_narrow;
    run_op(BOH_OP_SINGLE, `BOH_WIDTH_8, `BOH_BEATS_8, 0, 1'b1);
    run_op(BOH_OP_SINGLE, `BOH_WIDTH_16, `BOH_BEATS_16, 0, 1'b0);
  endtask : t_narrow
  task automatic t_double;
    run_op(BOH_OP_DOUBLE, `BOH_WIDTH_32, `BOH_BEATS_32, 0, 1'b0);
    run_op(BOH_OP_DOUBLE, `BOH_WIDTH_32, `BOH_BEATS_32, 1, 1'b1);
  endtask : t_double
  task automatic t_atomic;
    run_op(BOH_OP_ATOMIC, `BOH_WIDTH_16, `BOH_BEATS_16, 0, 1'b0);
  endtask : t_atomic
  task automatic t_freeze;
    clk_en = 1'b0;
    want = 1'b1;
    mst_write = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("frozen", bus_grant_out, 1'b0);
    chk("idle", core_busy, 1'b0);
    clk_en = 1'b1;
    @(negedge core_clk);
    chk("grant_thaw", bus_grant_out, 1'b1);
    release_bus();
    @(negedge core_clk);
  endtask : t_freeze
  initial begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    t_single();
    t_narrow();
    t_double();
    t_atomic();
    t_freeze();
    test_done();
  end
  initial begin
    #1000000;
    n_fail++;
    test_done();
  end
endmodule : tb_bus_ownership_handshake
`default_nettype wire
